//--- rtl/spsc_counter_set.v
// One set of receive and transmit statistics counters
`timescale 1ns/1ps
`default_nettype none
`include "spsc_regs.vh"
module spsc_counter_set #(
  parameter CW = 32
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          clrAll,
  input  wire          rxValid,
  input  wire [10:0]   rxLen,
  input  wire          rxFcsErr,
  input  wire          rxAlignErr,
  input  wire          rxGroup,
  input  wire          rxBcast,
  input  wire          rxDelivered,
  input  wire          rxDropped,
  input  wire          txReq,
  input  wire [1:0]    txClass,
  input  wire          txValid,
  input  wire [10:0]   txLen,
  input  wire [4:0]    sel,
  output wire [CW-1:0] selData
);
  wire [`SPSC_NUM_CNT*CW-1:0] cntFlat;
  reg  [`SPSC_NUM_CNT-1:0] inc;
  reg  [CW-1:0] rxOctAdd;
  reg  [CW-1:0] txOctAdd;
  wire rxBad;
  wire rxBc;
  wire rxMc;
  assign rxBad = rxFcsErr | rxAlignErr;
  assign rxBc  = rxBcast;
  assign rxMc  = rxGroup & ~rxBcast;
  always @*
  begin
    inc = {`SPSC_NUM_CNT{1'b0}};
    rxOctAdd = {{(CW-11){1'b0}}, rxLen};
    txOctAdd = {{(CW-11){1'b0}}, txLen} +
               {{(CW-11){1'b0}}, `SPSC_FRAMING_OCT};
    if (rxValid)
    begin
      inc[`SPSC_SEL_RXOCT]   = 1'b1; // [RQ1]
      inc[1] = (rxLen == `SPSC_LEN_64); // [RQ2]
      inc[2] = (rxLen > `SPSC_LEN_64) && (rxLen <= `SPSC_LEN_127); // [RQ3]
      inc[3] = (rxLen > `SPSC_LEN_127) && (rxLen <= `SPSC_LEN_255); // [RQ4]
      inc[4] = (rxLen > `SPSC_LEN_255) && (rxLen <= `SPSC_LEN_511); // [RQ5]
      inc[5] = (rxLen > `SPSC_LEN_511) && (rxLen <= `SPSC_LEN_1023); // [RQ6]
      inc[6] = (rxLen > `SPSC_LEN_1023) && (rxLen <= `SPSC_LEN_1518); // [RQ7]
      inc[7] = (rxLen > `SPSC_LEN_1518) && (rxLen <= `SPSC_LEN_1522); // [RQ8]
      inc[8] = (rxLen > `SPSC_LEN_1522); // [RQ9]
      inc[`SPSC_SEL_JABBER] = (rxLen > `SPSC_LEN_1518) & rxBad; // [RQ10]
      inc[`SPSC_SEL_RXMC]   = rxMc & ~rxBad; // [RQ11]
      inc[`SPSC_SEL_RXBC]   = rxBc & ~rxBad; // [RQ12]
      inc[`SPSC_SEL_RXUC]   = ~rxGroup & rxDelivered & ~rxBad; // [RQ13]
      inc[`SPSC_SEL_RXDISC] = rxDropped & ~rxBad; // [RQ14]
      inc[`SPSC_SEL_RXERR]  = rxBad; // [RQ17]
      inc[`SPSC_SEL_RXGOOD] = ~rxBad;
    end
    if (txReq)
    begin
      inc[`SPSC_SEL_TXUC] = (txClass == 2'h0); // [RQ15]
      inc[`SPSC_SEL_TXMC] = (txClass == 2'h1); // [RQ15]
      inc[`SPSC_SEL_TXBC] = (txClass == 2'h2); // [RQ15]
    end
    inc[`SPSC_SEL_TXOCT] = txValid; // [RQ16]
  end
  genvar i;
  generate
    for (i = 0; i < `SPSC_NUM_CNT; i = i + 1)
    begin : gCnt
      // Local register so each counter has exactly one driving block
      reg [CW-1:0] cnt_q;
      always @(posedge clk)
      begin
        if (rst)
          cnt_q <= {CW{1'b0}};
        else if (clrAll && i != `SPSC_SEL_RXDISC) // [RQ18]
          cnt_q <= {CW{1'b0}};
        else if (inc[i])
        begin
          if (i == `SPSC_SEL_RXOCT)
            cnt_q <= cnt_q + rxOctAdd; // [RQ1]
          else if (i == `SPSC_SEL_TXOCT)
            cnt_q <= cnt_q + txOctAdd; // [RQ16]
          else
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
      end
      assign cntFlat[i*CW +: CW] = cnt_q;
    end
  endgenerate
  assign selData = (sel < `SPSC_NUM_CNT) ? cntFlat[sel*CW +: CW] :
                   {CW{1'b0}};
endmodule
`default_nettype wire

//--- rtl/spsc_regs.vh
// Constants for the switch port statistics counter block
`ifndef SPSC_REGS_VH
`define SPSC_REGS_VH
`define SPSC_LEN_64      11'h040
`define SPSC_LEN_127     11'h07F
`define SPSC_LEN_255     11'h0FF
`define SPSC_LEN_511     11'h1FF
`define SPSC_LEN_1023    11'h3FF
`define SPSC_LEN_1518    11'h5EE
`define SPSC_LEN_1522    11'h5F2
`define SPSC_FRAMING_OCT 11'h008
// Counter select codes on the read port
`define SPSC_SEL_RXOCT   5'h00
`define SPSC_SEL_BIN0    5'h01
`define SPSC_SEL_RXUC    5'h09
`define SPSC_SEL_RXMC    5'h0A
`define SPSC_SEL_RXBC    5'h0B
`define SPSC_SEL_RXDISC  5'h0C
`define SPSC_SEL_RXERR   5'h0D
`define SPSC_SEL_JABBER  5'h0E
`define SPSC_SEL_TXUC    5'h0F
`define SPSC_SEL_TXMC    5'h10
`define SPSC_SEL_TXBC    5'h11
`define SPSC_SEL_TXOCT   5'h12
`define SPSC_SEL_RXGOOD  5'h13
`define SPSC_NUM_CNT     20
`endif

//--- rtl/spsc_stats_top.v
// Switch port statistics: per-port counter sets and table watermarks
// Behaviour
// RQ1 - Receive octets add every frame length
// RQ2 - Bin one counts 64-byte frames
// RQ3 - Bin two counts 65 to 127
// RQ4 - Bin three counts 128 to 255
// RQ5 - Bin four counts 256 to 511
// RQ6 - Bin five counts 512 to 1023
// RQ7 - Bin six counts 1024 to 1518
// RQ8 - Tagged bin counts 1519 to 1522
// RQ9 - Oversize bin counts above 1522
// RQ10 - Jabber: over 1518 with CRC/alignment error
// RQ11 - Multicast counter excludes broadcast frames
// RQ12 - Broadcast counter excludes multicast frames
// RQ13 - Unicast counts individual frames delivered upward
// RQ14 - Discards count dropped error-free frames
// RQ15 - Transmit class counters count requests
// RQ16 - Processor transmit octets include framing
// RQ17 - MAC error counter counts undeliverable frames
// RQ18 - Clear resets all but discard counters
// RQ19 - Address table high-water since reset
// RQ20 - Address entries in use, learned plus static
// RQ21 - VLAN high-water since reset
// RQ22 - Static and dynamic VLAN counts separate
// RQ23 - One counter set per port plus processor
`timescale 1ns/1ps
`default_nettype none
`include "spsc_regs.vh"
module spsc_stats_top #(
  parameter NPORT = 4,
  parameter PW    = 3,
  parameter CW    = 32,
  parameter TW    = 16,
  parameter VW    = 12
) (
  input  wire                clk,
  input  wire                rst,
  input  wire                clrAll,
  input  wire [NPORT:0]      rxValid,
  input  wire [NPORT*11+10:0] rxLen,
  input  wire [NPORT:0]      rxFcsErr,
  input  wire [NPORT:0]      rxAlignErr,
  input  wire [NPORT:0]      rxGroup,
  input  wire [NPORT:0]      rxBcast,
  input  wire [NPORT:0]      rxDelivered,
  input  wire [NPORT:0]      rxDropped,
  input  wire [NPORT:0]      txReq,
  input  wire [NPORT*2+1:0]  txClass,
  input  wire [NPORT:0]      txValid,
  input  wire [NPORT*11+10:0] txLen,
  input  wire [PW-1:0]       rdPort,
  input  wire [4:0]          rdSel,
  output reg  [CW-1:0]       rdData,
  input  wire [TW-1:0]       learnedEntries,
  input  wire [TW-1:0]       staticEntries,
  input  wire [VW-1:0]       staticVlans,
  input  wire [VW-1:0]       dynamicVlans,
  output reg  [TW-1:0]       addrInUse,
  output reg  [TW-1:0]       addrMaxUsed,
  output reg  [VW-1:0]       staticVlanCnt,
  output reg  [VW-1:0]       dynamicVlanCnt,
  output reg  [VW-1:0]       vlanMaxUsed
);
  // Index NPORT is the processor set; ports are 0..NPORT-1
  wire [CW-1:0] setData [0:NPORT];
  wire [TW-1:0] addrNow;
  wire [VW-1:0] vlanNow;
  genvar p;
  generate
    for (p = 0; p <= NPORT; p = p + 1)
    begin : gSet
      spsc_counter_set #(.CW(CW)) uSet ( // [RQ23]
        .clk         (clk),
        .rst         (rst),
        .clrAll      (clrAll),
        .rxValid     (rxValid[p]),
        .rxLen       (rxLen[p*11+10:p*11]),
        .rxFcsErr    (rxFcsErr[p]),
        .rxAlignErr  (rxAlignErr[p]),
        .rxGroup     (rxGroup[p]),
        .rxBcast     (rxBcast[p]),
        .rxDelivered (rxDelivered[p]),
        .rxDropped   (rxDropped[p]),
        .txReq       (txReq[p]),
        .txClass     (txClass[p*2+1:p*2]),
        .txValid     (txValid[p]),
        .txLen       (txLen[p*11+10:p*11]),
        .sel         (rdSel),
        .selData     (setData[p])
      );
    end
  endgenerate
  // Registered read mux; unused port indices read zero
  always @(posedge clk)
  begin
    if (rst)
      rdData <= {CW{1'b0}};
    else if (rdPort <= NPORT) // [RQ23]
      rdData <= setData[rdPort];
    else
      rdData <= {CW{1'b0}};
  end
  assign addrNow = learnedEntries + staticEntries; // [RQ20]
  assign vlanNow = staticVlans + dynamicVlans;
  // Watermarks survive the clear command; only reset empties them
  always @(posedge clk)
  begin
    if (rst)
    begin
      addrInUse      <= {TW{1'b0}};
      addrMaxUsed    <= {TW{1'b0}};
      staticVlanCnt  <= {VW{1'b0}};
      dynamicVlanCnt <= {VW{1'b0}};
      vlanMaxUsed    <= {VW{1'b0}};
    end
    else
    begin
      addrInUse      <= addrNow; // [RQ20]
      staticVlanCnt  <= staticVlans; // [RQ22]
      dynamicVlanCnt <= dynamicVlans; // [RQ22]
      if (addrNow > addrMaxUsed)
        addrMaxUsed <= addrNow; // [RQ19]
      if (vlanNow > vlanMaxUsed)
        vlanMaxUsed <= vlanNow; // [RQ21]
    end
  end
endmodule
`default_nettype wire

//--- verif/spsc_mac_model.sv
// Far side model: MAC receive and transmit event sources
`timescale 1ns/1ps
`default_nettype none
module spsc_mac_model #(parameter N = 5) (
  input  wire logic       clk,
  output logic [N-1:0]    rxValid, rxFcsErr, rxAlignErr, rxGroup, rxBcast,
  output logic [N-1:0]    rxDelivered, rxDropped, txReq, txValid,
  output logic [N*11-1:0] rxLen, txLen,
  output logic [N*2-1:0]  txClass
);
  initial {rxValid, rxFcsErr, rxAlignErr, rxGroup, rxBcast, rxDelivered,
    rxDropped, txReq, txValid, rxLen, txLen, txClass} = '0;
  // Qualifiers are inverted off the strobe so stale values never help
  task automatic ev(input int p, input logic r, input logic t,
    input logic [10:0] n, input logic [7:0] f);
    @(negedge clk);
    {rxValid[p], txReq[p], txValid[p]} = {r, t, t};
    {rxLen[p*11+:11], txLen[p*11+:11]} = {n, n};
    {rxFcsErr[p], rxAlignErr[p], rxGroup[p], rxBcast[p], rxDelivered[p],
      rxDropped[p], txClass[p*2+:2]} = f;
    @(negedge clk);
    {rxValid, txReq, txValid} = '0;
    {rxFcsErr, rxAlignErr, rxGroup, rxBcast, rxDelivered, rxDropped, rxLen,
      txLen, txClass} = ~{rxFcsErr, rxAlignErr, rxGroup, rxBcast,
      rxDelivered, rxDropped, rxLen, txLen, txClass};
  endtask
endmodule
`default_nettype wire

//--- verif/spsc_stats_sva.sv
// Checker on the statistics top ports
`timescale 1ns/1ps
`default_nettype none
module spsc_stats_sva #(parameter NPORT = 4, PW = 3, CW = 32, TW = 16,
  VW = 12) (
  input wire logic          clk, rst,
  input wire logic [PW-1:0] rdPort,
  input wire logic [4:0]    rdSel,
  input wire logic [CW-1:0] rdData,
  input wire logic [TW-1:0] learnedEntries, staticEntries, addrInUse,
  input wire logic [TW-1:0] addrMaxUsed,
  input wire logic [VW-1:0] staticVlans, dynamicVlans, staticVlanCnt,
  input wire logic [VW-1:0] dynamicVlanCnt, vlanMaxUsed
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_addr_used: assert property (!rst |=> addrInUse ==
    $past(learnedEntries) + $past(staticEntries)) else $error("addr use");
  a_addr_up: assert property (!rst |=>
    addrMaxUsed >= $past(addrMaxUsed)) else $error("addr peak fell");
  a_addr_peak: assert property (addrMaxUsed >= addrInUse)
    else $error("addr peak low");
  a_addr_step: assert property ($changed(addrMaxUsed) |->
    addrMaxUsed == addrInUse) else $error("addr peak jump");
  a_vlan_stat: assert property (!rst |=>
    staticVlanCnt == $past(staticVlans)) else $error("static vlans");
  a_vlan_dyn: assert property (!rst |=>
    dynamicVlanCnt == $past(dynamicVlans)) else $error("dynamic vlans");
  a_vlan_peak: assert property (vlanMaxUsed >=
    staticVlanCnt + dynamicVlanCnt) else $error("vlan peak low");
  a_vlan_step: assert property ($changed(vlanMaxUsed) |->
    vlanMaxUsed == staticVlanCnt + dynamicVlanCnt) else $error("vlan jump");
  a_bad_sel: assert property (rdSel > 5'h13 || rdPort > NPORT |=>
    rdData == '0) else $error("bad select");
  c_peak: cover property (addrMaxUsed > addrInUse);
  c_vlan: cover property (vlanMaxUsed > staticVlanCnt);
  c_sel: cover property (rdPort > NPORT);
endmodule
bind spsc_stats_top spsc_stats_sva #(.NPORT(NPORT), .PW(PW), .CW(CW),
  .TW(TW), .VW(VW)) spsc_stats_sva_inst (.*);
`default_nettype wire

//--- verif/spsc_stats_tb_top.sv
// Self-checking bench for the switch port statistics block
`timescale 1ns/1ps
`default_nettype none
module spsc_stats_tb_top;
  logic        clk = 1'b0;
  logic        rst, clrAll;
  logic [4:0]  rxValid, rxFcsErr, rxAlignErr, rxGroup, rxBcast, rxDropped;
  logic [4:0]  rxDelivered, txReq, txValid, rdSel;
  logic [54:0] rxLen, txLen;
  logic [9:0]  txClass;
  logic [2:0]  rdPort;
  logic [31:0] rdData;
  logic [15:0] learnedEntries, staticEntries, addrInUse, addrMaxUsed;
  logic [11:0] staticVlans, dynamicVlans, staticVlanCnt, dynamicVlanCnt;
  logic [11:0] vlanMaxUsed;
  int          error_cnt = 0;
  int          checked = 0;
  spsc_stats_top spsc_stats_top_inst (.*);
  spsc_mac_model spsc_mac_model_inst (.*);
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic rd(input logic [2:0] p, input logic [4:0] s,
    input logic [31:0] e);
    @(negedge clk);
    rdPort = p;
    rdSel = s;
    @(negedge clk);
    chk(rdData, e);
  endtask
  task automatic t_rx();
    logic [10:0] n[14] = '{11'h040, 11'h041, 11'h07F, 11'h080, 11'h0FF,
      11'h100, 11'h1FF, 11'h200, 11'h3FF, 11'h400, 11'h5EE, 11'h5EF,
      11'h5F2, 11'h5F3};
    logic [7:0] f[14] = '{8'h20, 8'h30, 8'h08, 8'h00, 8'h04, 8'h84, 8'h30,
      8'h00, 8'h00, 8'h00, 8'h80, 8'h40, 8'h00, 8'h80};
    logic [3:0] e[15] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2,
      4'h1, 4'h1, 4'h1, 4'h2, 4'h1, 4'h4, 4'h2};
    logic [31:0] oct = 32'h0;
    for (int i = 0; i < 14; i++)
    begin
      spsc_mac_model_inst.ev(1, 1'b1, 1'b0, n[i], f[i]);
      oct += 32'(n[i]);
    end
    rd(3'h1, 5'h00, oct);
    for (int s = 1; s < 9; s++)
      rd(3'h1, 5'(s), 32'(e[s]));
    for (int s = 9; s < 15; s++)
      rd(3'h1, 5'(s), 32'(e[s]));
    rd(3'h2, 5'h00, 32'h0);
    rd(3'h5, 5'h01, 32'h0);
    rd(3'h1, 5'h1F, 32'h0);
    rd(3'h1, 5'h13, 32'hA);
    $display("rx test done");
  endtask
  task automatic t_tx();
    for (int i = 0; i < 4; i++)
      spsc_mac_model_inst.ev(4, 1'b0, 1'b1, i ? 11'h03C : 11'h064,
        8'(i > 1 ? 2 : i));
    rd(3'h4, 5'h0F, 32'h1);
    rd(3'h4, 5'h10, 32'h1);
    rd(3'h4, 5'h11, 32'h2);
    rd(3'h4, 5'h12, 32'h138);
    $display("tx test done");
  endtask
  task automatic t_clr();
    // A frame in the clear cycle must be lost: clear wins
    fork
      spsc_mac_model_inst.ev(1, 1'b1, 1'b0, 11'h040, 8'h00);
      begin
        @(negedge clk);
        clrAll = 1'b1;
        @(negedge clk);
        clrAll = 1'b0;
      end
    join
    rd(3'h1, 5'h00, 32'h0);
    rd(3'h1, 5'h01, 32'h0);
    rd(3'h1, 5'h0C, 32'h1);
    rd(3'h4, 5'h12, 32'h0);
    $display("clear test done");
  endtask
  task automatic t_tbl();
    @(negedge clk);
    {learnedEntries, staticEntries} = {16'h0030, 16'h0005};
    {staticVlans, dynamicVlans} = {12'h003, 12'h004};
    @(negedge clk);
    {learnedEntries, dynamicVlans} = {16'h0010, 12'h001};
    @(negedge clk);
    chk(32'(addrInUse), 32'h15);
    chk(32'(addrMaxUsed), 32'h35);
    chk(32'(vlanMaxUsed), 32'h7);
    chk(32'(dynamicVlanCnt), 32'h1);
    chk(32'(staticVlanCnt), 32'h3);
    $display("table test done");
  endtask
  task automatic results();
    $display("%0d checks, %0d mismatches", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    {rst, clrAll, rdPort, rdSel} = 10'h200;
    {learnedEntries, staticEntries, staticVlans, dynamicVlans} = '0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_rx();
    t_tx();
    t_clr();
    t_tbl();
    results();
  end
  initial
  begin
    #100000;
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
